// ==== src/vm_exit_reason_encoder.sv ====
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module vm_exit_reason_encoder (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [vm_exit_pkg::ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire vm_exit_pkg::exit_events_s events,
   output vm_exit_pkg::reason_write_s reasonWrite,
   output vm_exit_pkg::field_sel_s fieldSel
);

   logic [vm_exit_pkg::CTRL_W-1:0] ctrl;
   logic [31:0] excBitmap;
   logic [vm_exit_pkg::ENC_W-1:0] fieldEnc;
   logic [31:0] lastReason;
   logic [vm_exit_pkg::COUNT_W-1:0] exitCount;

   // exit cause qualification
   logic hitException;
   logic hitNmi;
   logic hitExtInt;
   logic hitTriple;
   logic hitStartup;
   logic hitMgmtIo;
   logic hitMgmtOther;
   logic hitIntWin;
   logic hitNmiWin;
   logic anyExit;
   logic [vm_exit_pkg::BASIC_W-1:0] next_basic;
   logic [31:0] next_reason;
   logic next_valid;

   assign hitException = events.excValid
      && excBitmap[events.excVector];
   assign hitNmi = events.nmiDelivered
      && ctrl[vm_exit_pkg::CTRL_NMI_EXIT];
   assign hitExtInt = events.extInterrupt
      && ctrl[vm_exit_pkg::CTRL_EXTINT_EXIT];
   assign hitTriple = events.dblFaultExc
      && !excBitmap[events.dblFaultVector];
   assign hitStartup = events.startupMsg
      && events.waitForStartup;
   assign hitMgmtIo = events.systemMgmtInterrupt
      && events.afterIoRetire;
   assign hitMgmtOther = events.systemMgmtInterrupt
      && !events.afterIoRetire;
   assign hitIntWin = events.instrBoundary && events.interruptFlag
      && !events.blockBySetIntEnable && !events.blockByStackSegLoad
      && ctrl[vm_exit_pkg::CTRL_INTWIN_EXIT];
   assign hitNmiWin = events.instrBoundary && !events.blockByVirtNmi
      && !events.blockByStackSegLoad
      && ctrl[vm_exit_pkg::CTRL_NMIWIN_EXIT];

   assign anyExit = hitException || hitNmi || hitExtInt || hitTriple
      || events.initSignal || hitStartup || events.systemMgmtInterrupt
      || hitIntWin || hitNmiWin || events.taskSwitch;

   // one reason per exit, fixed priority
   always_comb begin
      next_basic = vm_exit_pkg::RSN_EXC_NMI;
      if (hitTriple) begin
         next_basic = vm_exit_pkg::RSN_TRIPLE;
      end else if (events.initSignal) begin
         next_basic = vm_exit_pkg::RSN_INIT;
      end else if (hitStartup) begin
         next_basic = vm_exit_pkg::RSN_STARTUP;
      end else if (hitMgmtIo) begin
         next_basic = vm_exit_pkg::RSN_MGMT_IO;
      end else if (hitMgmtOther) begin
         next_basic = vm_exit_pkg::RSN_MGMT_OTHER;
      end else if (events.taskSwitch) begin
         next_basic = vm_exit_pkg::RSN_TASK_SW;
      end else if (hitException || hitNmi) begin
         next_basic = vm_exit_pkg::RSN_EXC_NMI;
      end else if (hitExtInt) begin
         next_basic = vm_exit_pkg::RSN_EXT_INT;
      end else if (hitNmiWin) begin
         next_basic = vm_exit_pkg::RSN_NMI_WIN;
      end else if (hitIntWin) begin
         next_basic = vm_exit_pkg::RSN_INT_WIN;
      end
   end

   // entry failure outranks exits, flagged in the top bit
   always_comb begin
      next_reason = '0;
      next_valid = 1'b0;
      if (events.entryFail) begin
         next_valid = 1'b1;
         next_reason[vm_exit_pkg::BASIC_W-1:0] = events.entryFailBasic;
         next_reason[vm_exit_pkg::ENTRY_FAIL_BIT] = 1'b1;
      end else if (anyExit) begin
         next_valid = 1'b1;
         next_reason[vm_exit_pkg::BASIC_W-1:0] = next_basic;
      end
   end

   // reason write toward the control structure
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reasonWrite <= '0;
      end else begin
         reasonWrite.valid <= next_valid;
         if (next_valid) begin
            reasonWrite.reason <= next_reason;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         lastReason <= '0;
         exitCount <= '0;
      end else if (next_valid) begin
         lastReason <= next_reason;
         exitCount <= exitCount + 1'b1;
      end
   end

   // field encoding decode
   logic encNatural;
   logic encHost;
   logic encPattern;
   logic [vm_exit_pkg::INDEX_W-1:0] encIndex;
   typedef vm_exit_pkg::field_sel_s field_decode_t;
   field_decode_t next_sel;

   assign encNatural = fieldEnc[vm_exit_pkg::WIDTH_HI:vm_exit_pkg::WIDTH_LO]
      == vm_exit_pkg::WIDTH_NATURAL
      && !fieldEnc[vm_exit_pkg::ACCESS_BIT];
   assign encHost = fieldEnc[vm_exit_pkg::AREA_HI:vm_exit_pkg::AREA_LO]
      == vm_exit_pkg::AREA_HOST;
   assign encIndex =
      fieldEnc[vm_exit_pkg::INDEX_HI:vm_exit_pkg::INDEX_LO];
   assign encPattern = fieldEnc[vm_exit_pkg::PAT_HI:vm_exit_pkg::PAT_LO]
      == vm_exit_pkg::HOST_NAT_PATTERN
      && !fieldEnc[vm_exit_pkg::ACCESS_BIT];

   always_comb begin
      next_sel = '0;
      next_sel.natural = encNatural;
      next_sel.host = encHost;
      next_sel.index = encIndex;
      next_sel.valid = encPattern
         && encIndex <= vm_exit_pkg::HOST_NAT_LAST;
      next_sel.ctrlRegSel[0] =
         fieldEnc == vm_exit_pkg::ENC_HOST_CTRL_ZERO;
      next_sel.ctrlRegSel[1] = fieldEnc == vm_exit_pkg::ENC_HOST_PT_BASE;
      next_sel.ctrlRegSel[2] = fieldEnc == vm_exit_pkg::ENC_HOST_CTRL_FOUR;
      next_sel.fastSyscallSel[0] =
         fieldEnc == vm_exit_pkg::ENC_HOST_SYS_SP;
      next_sel.fastSyscallSel[1] = fieldEnc == vm_exit_pkg::ENC_HOST_SYS_IP;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fieldSel <= '0;
      end else begin
         fieldSel <= next_sel;
      end
   end

   // register writes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl <= vm_exit_pkg::CTRL_RESET;
         excBitmap <= vm_exit_pkg::BITMAP_RESET;
         fieldEnc <= '0;
      end else if (regWr) begin
         case (regAddr)
            vm_exit_pkg::REG_CTRL: begin
               ctrl <= regWdata[vm_exit_pkg::CTRL_W-1:0];
            end
            vm_exit_pkg::REG_EXC_BITMAP: begin
               excBitmap <= regWdata;
            end
            vm_exit_pkg::REG_FIELD_ENC: begin
               fieldEnc <= regWdata[vm_exit_pkg::ENC_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // register reads, data one cycle later
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         regRdata <= '0;
      end else begin
         regRdata <= '0;
         if (regRd) begin
            case (regAddr)
               vm_exit_pkg::REG_CTRL: begin
                  regRdata[vm_exit_pkg::CTRL_W-1:0] <= ctrl;
               end
               vm_exit_pkg::REG_EXC_BITMAP: begin
                  regRdata <= excBitmap;
               end
               vm_exit_pkg::REG_EXIT_REASON: begin
                  regRdata <= lastReason;
               end
               vm_exit_pkg::REG_EXIT_COUNT: begin
                  regRdata <= exitCount;
               end
               vm_exit_pkg::REG_FIELD_ENC: begin
                  regRdata[vm_exit_pkg::ENC_W-1:0] <= fieldEnc;
               end
               vm_exit_pkg::REG_FIELD_SEL: begin
                  regRdata[vm_exit_pkg::INDEX_W-1:0] <= fieldSel.index;
                  regRdata[vm_exit_pkg::SEL_NATURAL] <= fieldSel.natural;
                  regRdata[vm_exit_pkg::SEL_HOST] <= fieldSel.host;
                  regRdata[vm_exit_pkg::SEL_VALID] <= fieldSel.valid;
                  regRdata[vm_exit_pkg::SEL_NAMED_LO +: 5] <=
                     {fieldSel.fastSyscallSel, fieldSel.ctrlRegSel};
               end
               default: begin
               end
            endcase
         end
      end
   end

endmodule

// ==== src/vm_exit_pkg.sv ====
package vm_exit_pkg;

   // register port
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_EXC_BITMAP = 8'h04;
   localparam logic [ADDR_W-1:0] REG_EXIT_REASON = 8'h08;
   localparam logic [ADDR_W-1:0] REG_EXIT_COUNT = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_FIELD_ENC = 8'h10;
   localparam logic [ADDR_W-1:0] REG_FIELD_SEL = 8'h14;

   // control register bits
   localparam int CTRL_NMI_EXIT = 0;
   localparam int CTRL_EXTINT_EXIT = 1;
   localparam int CTRL_INTWIN_EXIT = 2;
   localparam int CTRL_NMIWIN_EXIT = 3;
   localparam int CTRL_W = 4;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
   localparam logic [31:0] BITMAP_RESET = 32'h0000_0000;

   // field encoding layout
   localparam int ENC_W = 16;
   localparam int WIDTH_HI = 14;
   localparam int WIDTH_LO = 13;
   localparam int AREA_HI = 11;
   localparam int AREA_LO = 10;
   localparam int INDEX_HI = 9;
   localparam int INDEX_LO = 1;
   localparam int ACCESS_BIT = 0;
   localparam int INDEX_W = 9;
   localparam logic [1:0] WIDTH_NATURAL = 2'h3;
   localparam logic [1:0] AREA_HOST = 2'h3;
   localparam int PAT_HI = 15;
   localparam int PAT_LO = 10;
   localparam logic [5:0] HOST_NAT_PATTERN = 6'h1b;
   localparam logic [INDEX_W-1:0] HOST_NAT_LAST = 9'h00b;
   localparam logic [ENC_W-1:0] ENC_HOST_CTRL_ZERO = 16'h6c00;
   localparam logic [ENC_W-1:0] ENC_HOST_PT_BASE = 16'h6c02;
   localparam logic [ENC_W-1:0] ENC_HOST_CTRL_FOUR = 16'h6c04;
   localparam logic [ENC_W-1:0] ENC_HOST_SYS_SP = 16'h6c10;
   localparam logic [ENC_W-1:0] ENC_HOST_SYS_IP = 16'h6c12;

   // field-select readback layout
   localparam int SEL_NATURAL = 16;
   localparam int SEL_HOST = 17;
   localparam int SEL_VALID = 18;
   localparam int SEL_NAMED_LO = 24;

   // exit reason word
   localparam int BASIC_W = 16;
   localparam int ENTRY_FAIL_BIT = 31;
   localparam logic [BASIC_W-1:0] RSN_EXC_NMI = 16'h0000;
   localparam logic [BASIC_W-1:0] RSN_EXT_INT = 16'h0001;
   localparam logic [BASIC_W-1:0] RSN_TRIPLE = 16'h0002;
   localparam logic [BASIC_W-1:0] RSN_INIT = 16'h0003;
   localparam logic [BASIC_W-1:0] RSN_STARTUP = 16'h0004;
   localparam logic [BASIC_W-1:0] RSN_MGMT_IO = 16'h0005;
   localparam logic [BASIC_W-1:0] RSN_MGMT_OTHER = 16'h0006;
   localparam logic [BASIC_W-1:0] RSN_INT_WIN = 16'h0007;
   localparam logic [BASIC_W-1:0] RSN_NMI_WIN = 16'h0008;
   localparam logic [BASIC_W-1:0] RSN_TASK_SW = 16'h0009;

   localparam int VEC_W = 5;
   localparam int COUNT_W = 32;

   typedef struct packed {
      logic excValid;
      logic [VEC_W-1:0] excVector;
      logic dblFaultExc;
      logic [VEC_W-1:0] dblFaultVector;
      logic nmiDelivered;
      logic extInterrupt;
      logic initSignal;
      logic startupMsg;
      logic waitForStartup;
      logic systemMgmtInterrupt;
      logic afterIoRetire;
      logic instrBoundary;
      logic interruptFlag;
      logic blockBySetIntEnable;
      logic blockByStackSegLoad;
      logic blockByVirtNmi;
      logic taskSwitch;
      logic entryFail;
      logic [BASIC_W-1:0] entryFailBasic;
   } exit_events_s;

   typedef struct packed {
      logic valid;
      logic [31:0] reason;
   } reason_write_s;

   typedef struct packed {
      logic valid;
      logic natural;
      logic host;
      logic [INDEX_W-1:0] index;
      logic [2:0] ctrlRegSel;
      logic [1:0] fastSyscallSel;
   } field_sel_s;

endpackage

// ==== tb/vm_exit_props.sv ====
`timescale 1ns/1ps
module vm_exit_props (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [vm_exit_pkg::ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdata,
   input wire vm_exit_pkg::exit_events_s events,
   input wire vm_exit_pkg::reason_write_s reasonWrite,
   input wire vm_exit_pkg::field_sel_s fieldSel
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   vm_exit_pkg::exit_events_s e;
   logic [3:0] ctrl;
   logic [31:0] bmap;
   logic [31:0] expR;
   logic anyQ;
   logic ib;
   assign e = events;
   assign ib = e.instrBoundary && !e.blockByStackSegLoad;
   // shadow of the controls
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl <= '0;
         bmap <= '0;
      end else if (regWr && regAddr == 8'h00) begin
         ctrl <= regWdata[3:0];
      end else if (regWr && regAddr == 8'h04) begin
         bmap <= regWdata;
      end
   end
   // expected reason by priority
   always_comb begin
      anyQ = 1'b1;
      expR = '0;
      if (e.entryFail) expR = {1'b1, 15'h0, e.entryFailBasic};
      else if (e.dblFaultExc && !bmap[e.dblFaultVector]) expR = 32'h2;
      else if (e.initSignal) expR = 32'h3;
      else if (e.startupMsg && e.waitForStartup) expR = 32'h4;
      else if (e.systemMgmtInterrupt) expR = e.afterIoRetire ? 32'h5 : 32'h6;
      else if (e.taskSwitch) expR = 32'h9;
      else if (e.excValid && bmap[e.excVector]) expR = 32'h0;
      else if (e.nmiDelivered && ctrl[0]) expR = 32'h0;
      else if (e.extInterrupt && ctrl[1]) expR = 32'h1;
      else if (ib && !e.blockByVirtNmi && ctrl[3]) expR = 32'h8;
      else if (ib && e.interruptFlag && !e.blockBySetIntEnable && ctrl[2])
         expR = 32'h7;
      else anyQ = 1'b0;
   end
   sequence encPtBase;
      regWr && regAddr == 8'h10 && regWdata[15:0] == 16'h6c02;
   endsequence
   sequence encKept;
      encPtBase ##1 !regWr;
   endsequence
   a_reason_value: assert property (anyQ |=> reasonWrite.valid
      && reasonWrite.reason == $past(expR)) else $error("wrong reason");
   a_no_spurious: assert property (!anyQ |=> !reasonWrite.valid)
      else $error("spurious exit");
   a_upper_zero: assert property (reasonWrite.valid |->
      reasonWrite.reason[30:16] == 15'h0) else $error("upper bits set");
   a_entry_flag: assert property (e.entryFail |=>
      reasonWrite.reason[31]) else $error("entry flag missing");
   a_reason_hold: assert property (!reasonWrite.valid |->
      $stable(reasonWrite.reason)) else $error("reason changed");
   a_cr3_decode: assert property (encKept |=> fieldSel.valid
      && fieldSel.ctrlRegSel == 3'b010) else $error("table base decode");
   a_fast_decode: assert property (fieldSel.fastSyscallSel[0] |->
      fieldSel.valid && fieldSel.index == 9'h8) else $error("fast decode");
   a_cr_onehot: assert property (fieldSel.ctrlRegSel != 3'h0 |->
      $onehot(fieldSel.ctrlRegSel) && fieldSel.index < 9'h3)
      else $error("ctrl select");
   a_valid_range: assert property (fieldSel.valid |-> fieldSel.host
      && fieldSel.natural && fieldSel.index <= 9'h00b)
      else $error("valid range");
endmodule
bind vm_exit_reason_encoder vm_exit_props chk (.mclk(mclk),
   .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .events(events),
   .reasonWrite(reasonWrite), .fieldSel(fieldSel));

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   vm_exit_pkg::exit_events_s events = '0;
   vm_exit_pkg::reason_write_s reasonWrite;
   vm_exit_pkg::field_sel_s fieldSel;
   vm_exit_pkg::exit_events_s e;
   logic [31:0] rdQ[$];
   logic [31:0] exQ[$];
   logic [31:0] bmap;
   logic [31:0] last = 32'h0;
   logic [15:0] encs[11] = '{16'h6c00, 16'h6c02, 16'h6c04, 16'h6c10,
      16'h6c12, 16'h6c16, 16'h6c18, 16'h6c03, 16'h4c00, 16'h6800, 16'h6c06};
   logic rdSeen = 1'b0;
   int num_errors = 0;
   int n_compared = 0;
   int nExits = 0;
   int v;
   vm_exit_reason_encoder uut (.mclk(mclk), .sys_rst(sys_rst),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .events(events), .reasonWrite(reasonWrite),
      .fieldSel(fieldSel));
   always #2.5 mclk = ~mclk;
   task automatic cmp(string what, logic [31:0] x, logic [31:0] got);
      n_compared++;
      if (got !== x) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, x, got);
      end
   endtask
   task automatic finish_test();
      if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] x);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      rdQ.push_back(x);
      @(posedge mclk);
      regRd <= 1'b0;
   endtask
   task automatic ev(vm_exit_pkg::exit_events_s s, bit q, logic [31:0] x);
      @(posedge mclk);
      events <= s;
      if (q) begin
         exQ.push_back(x);
         nExits++;
         last = x;
      end
      @(posedge mclk);
      events <= '0;
   endtask
   function automatic logic [31:0] selx(logic [15:0] c);
      logic [8:0] i;
      logic ok;
      i = c[9:1];
      ok = c[15:10] == 6'h1b && !c[0] && i <= 9'h00b;
      selx = {3'h0, ok && i == 9'h9, ok && i == 9'h8, ok && i == 9'h2,
         ok && i == 9'h1, ok && i == 9'h0, 5'h0, ok, c[11:10] == 2'h3,
         c[14:13] == 2'h3 && !c[0], 7'h0, i};
   endfunction
   always @(posedge mclk) rdSeen <= regRd;
   always @(negedge mclk) begin
      if (rdSeen) cmp("read data", rdQ.size() ? rdQ.pop_front() : 'x,
         regRdata);
      if (reasonWrite.valid !== 1'b0) cmp("exit reason",
         exQ.size() ? exQ.pop_front() : 'x, reasonWrite.reason);
   end
   initial begin
      #50000;
      num_errors++;
      finish_test();
   end
   initial begin
      void'($urandom(32'hf9abca23));
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0);
      rd(8'h30, 32'h0);
      bmap = $urandom & ~32'h2;
      wr(8'h04, bmap);
      rd(8'h04, bmap);
      for (int p = 0; p < 2; p++) begin
         wr(8'h00, p ? 32'h0000_000f : 32'hffff_fff0);
         rd(8'h00, p ? 32'hf : 32'h0);
         for (int i = 0; i < 15; i++) begin
            e = '0;
            e.instrBoundary = i inside {7, 8, 13, 14};
            e.interruptFlag = i inside {7, 13, 14};
            e.blockByVirtNmi = i inside {7, 14};
            e.blockByStackSegLoad = i == 13;
            e.blockBySetIntEnable = i == 14;
            e.nmiDelivered = i == 0;
            e.extInterrupt = i inside {1, 10};
            e.dblFaultExc = i == 2;
            e.dblFaultVector = 5'd1;
            e.initSignal = i inside {3, 10, 11};
            e.startupMsg = i inside {4, 12};
            e.waitForStartup = i == 4;
            e.systemMgmtInterrupt = i inside {5, 6};
            e.afterIoRetire = i == 5;
            e.taskSwitch = i inside {9, 10};
            e.entryFail = i == 11;
            e.entryFailBasic = 16'h0021;
            ev(e, i < 12 && (p == 1 || !(i inside {0, 1, 7, 8})),
               i == 11 ? 32'h8000_0021 : i == 10 ? 32'h3 : 32'(i));
         end
      end
      repeat (8) begin
         v = $urandom % 32;
         e = '0;
         e.excValid = 1'b1;
         e.excVector = 5'(v);
         ev(e, bmap[v], 32'h0);
      end
      rd(8'h0c, 32'(nExits));
      rd(8'h08, last);
      for (int i = 0; i < 12; i++) begin
         v = i < 11 ? encs[i] : $urandom;
         wr(8'h10, {16'hffff, 16'(v)});
         rd(8'h10, {16'h0, 16'(v)});
         rd(8'h14, selx(16'(v)));
      end
      repeat (4) @(posedge mclk);
      cmp("pending exits", 32'h0, 32'(exQ.size()));
      cmp("pending reads", 32'h0, 32'(rdQ.size()));
      finish_test();
   end
endmodule
